/* shared/rtpp_pkg.sv */
// Package of constants and carrier types for the tape record parser.
package rtpp_pkg;

    // Character codes of the tape stream.
    localparam logic [7:0] CH_START = 8'h42;
    localparam logic [7:0] CH_HIGH  = 8'h50;
    localparam logic [7:0] CH_LOW   = 8'h4e;
    localparam logic [7:0] CH_END   = 8'h46;

    // Default geometry and reset values.
    localparam int         DEF_WORDS     = 256;
    localparam int         DEF_DATA_W    = 8;
    localparam logic [7:0] RST_CHAR      = 8'h00;

    typedef struct packed {
        logic [7:0] code;
    } rtpp_char_t;

endpackage

/* rtl/rtpp_sync.sv */
// Two-flop synchroniser for the character strobe coming from the reader.
module rtpp_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // Level in and out
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic s1;
        logic s2;
    } rtpp_sync_st_t;

    rtpp_sync_st_t st_r;
    rtpp_sync_st_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.s2;

endmodule

/* rtl/rtpp_buf2.sv */
// Two-entry skid buffer carrying finished address and data words.
module rtpp_buf2 #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic [1:0]   cnt;
    } rtpp_buf_st_t;

    rtpp_buf_st_t st_r;
    rtpp_buf_st_t st_nxt;
    logic         push;
    logic         pop;

    always_comb begin
        st_nxt = st_r;
        push   = in_valid && (st_r.cnt != 2'h2);
        pop    = out_ready && (st_r.cnt != 2'h0);
        if (pop) begin
            st_nxt.d0 = st_r.d1;
        end
        if (push) begin
            if ((st_r.cnt == 2'h0) || (st_r.cnt == 2'h1 && pop)) begin
                st_nxt.d0 = in_data;
            end else begin
                st_nxt.d1 = in_data;
            end
        end
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready  = (st_r.cnt != 2'h2);
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_data  = st_r.d0;

endmodule

/* rtl/rtpp_parser.sv */
// Paper tape record parser producing address and data words for a PROM programmer.

// Operation
// - Leader characters before first record ignored.
// - One record per word, count is parameter.
// - Record is start, bit characters, end.
// - First record address zero, then increments.
// - High character sets bit, low clears.
// - First bit character is highest bit.
// - Trailer characters after last record ignored.
// - Between records skip all but start, end.
module rtpp_parser #(
    parameter int WORDS  = rtpp_pkg::DEF_WORDS,
    parameter int DATA_W = rtpp_pkg::DEF_DATA_W,
    parameter int ADDR_W = $clog2(WORDS)
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // Character input from the tape reader, strobe toggles per character
    input  wire logic              char_tgl,
    input  wire logic [7:0]        char_code,
    // Word output towards the programmer
    output logic                   word_valid,
    input  wire logic              word_ready,
    output logic [ADDR_W-1:0]      word_addr,
    output logic [DATA_W-1:0]      word_data,
    // Status
    output logic                   rec_error,
    output logic                   done
);

    // Characters arrive with a toggle rather than a pulse so that the reader
    // may run from any clock. The toggle and the code each pass two flops,
    // which keeps them aligned, so the code is settled whenever the moved
    // toggle is seen. The intake has no overrun detection: a reader that
    // toggles twice while a full buffer holds intake back loses both
    // characters, so the source must pace itself against the programmer.

    localparam int BW = ADDR_W + DATA_W;
    localparam int CW = $clog2(DATA_W + 2);

    // Bit count at which a record holds a whole word.
    localparam logic [CW-1:0]   FULL_CNT  = CW'(DATA_W);
    // Address of the final record; reaching it ends the tape.
    localparam logic [ADDR_W:0] LAST_ADDR = (ADDR_W + 1)'(WORDS - 1);

    // Record walk: between records, gathering bits, waiting for the end
    // character, and finished once every word has been taken in.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_BITS  = 4'h2,
        ST_CLOSE = 4'h4,
        ST_FULL  = 4'h8
    } rtpp_state_t;

    // Meaning of one received character, one bit per class.
    typedef enum logic [4:0] {
        CC_START = 5'h01,
        CC_HIGH  = 5'h02,
        CC_LOW   = 5'h04,
        CC_END   = 5'h08,
        CC_OTHER = 5'h10
    } rtpp_class_t;

    typedef struct packed {
        rtpp_state_t          state;
        logic                 tgl_seen;
        logic [7:0]           code_m;
        logic [7:0]           code_s;
        rtpp_pkg::rtpp_char_t ch;
        logic                 ch_new;
        logic [DATA_W-1:0]    shift;
        logic [CW-1:0]        nbits;
        logic [ADDR_W:0]      addr;
        logic                 push;
        logic [BW-1:0]        push_word;
        logic                 err;
        logic                 done;
        logic                 ovalid;
        logic [BW-1:0]        oword;
    } rtpp_st_t;

    rtpp_st_t      st_r;
    rtpp_st_t      st_nxt;
    rtpp_class_t   cls;
    logic          tgl_s;
    logic          tgl_moved;
    logic          buf_in_ready;
    logic          buf_out_valid;
    logic [BW-1:0] buf_out_data;
    logic          take_out;

    // Sorts a received code into the classes the record walk acts on.
    function automatic rtpp_class_t classify(input logic [7:0] c);
        case (c)
            rtpp_pkg::CH_START: classify = CC_START;
            rtpp_pkg::CH_HIGH:  classify = CC_HIGH;
            rtpp_pkg::CH_LOW:   classify = CC_LOW;
            rtpp_pkg::CH_END:   classify = CC_END;
            default:            classify = CC_OTHER;
        endcase
    endfunction

    // Moves one bit in at the bottom, so the first bit ends up on top.
    function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] s,
                                                   input logic              b);
        shift_in = {s[DATA_W-2:0], b};
    endfunction

    // Joins the address and the data into one buffer entry.
    function automatic logic [BW-1:0] pack_word(input logic [ADDR_W:0]   a,
                                                input logic [DATA_W-1:0] d);
        pack_word = {a[ADDR_W-1:0], d};
    endfunction

    assign cls       = classify(st_r.ch.code);
    assign tgl_moved = (tgl_s != st_r.tgl_seen);

    rtpp_sync u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (char_tgl),
        .dout     (tgl_s)
    );

    // The output register is refilled when empty or taken this cycle.
    assign take_out = !st_r.ovalid || word_ready;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.push     = 1'b0;
        st_nxt.ch_new   = 1'b0;
        st_nxt.tgl_seen = tgl_s;
        // The code pin gets two flops of its own, the same depth as the toggle.
        st_nxt.code_m   = char_code;
        st_nxt.code_s   = st_r.code_m;
        // A full buffer leaves the toggle unconsumed, so the character waits.
        if (tgl_moved && buf_in_ready) begin
            st_nxt.ch.code = st_r.code_s;
            st_nxt.ch_new  = 1'b1;
        end else if (tgl_moved) begin
            st_nxt.tgl_seen = st_r.tgl_seen;
        end
        if (st_r.ch_new) begin
            case (st_r.state)
                ST_IDLE: begin
                    // Leader, trailer, line breaks and other filler are skipped.
                    if (cls == CC_START) begin
                        st_nxt.state = ST_BITS;
                        st_nxt.nbits = '0;
                        st_nxt.shift = '0;
                    end else if (cls == CC_END) begin
                        st_nxt.err = 1'b1;
                    end
                end
                ST_BITS: begin
                    if (cls == CC_HIGH || cls == CC_LOW) begin
                        st_nxt.shift = shift_in(st_r.shift, cls == CC_HIGH);
                        st_nxt.nbits = st_r.nbits + CW'(1);
                        if (st_r.nbits + CW'(1) == FULL_CNT) begin
                            st_nxt.state = ST_CLOSE;
                        end
                    end else begin
                        // Short record, nested start or foreign character.
                        st_nxt.state = ST_IDLE;
                        st_nxt.err   = 1'b1;
                    end
                end
                ST_CLOSE: begin
                    if (cls == CC_END) begin
                        st_nxt.push      = 1'b1;
                        st_nxt.push_word = pack_word(st_r.addr, st_r.shift);
                        st_nxt.addr      = st_r.addr + (ADDR_W + 1)'(1);
                        if (st_r.addr == LAST_ADDR) begin
                            st_nxt.state = ST_FULL;
                            st_nxt.done  = 1'b1;
                        end else begin
                            st_nxt.state = ST_IDLE;
                        end
                    end else begin
                        // An extra bit or any other character drops the record.
                        st_nxt.state = ST_IDLE;
                        st_nxt.err   = 1'b1;
                    end
                end
                ST_FULL: begin
                    // Every word is in; the rest of the tape is ignored.
                    st_nxt.state = ST_FULL;
                end
                default: begin
                    st_nxt.state = ST_IDLE;
                end
            endcase
        end
        if (take_out) begin
            st_nxt.ovalid = buf_out_valid;
            st_nxt.oword  = buf_out_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r         <= '0;
            st_r.state   <= ST_IDLE;
            st_r.ch.code <= rtpp_pkg::RST_CHAR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The buffer absorbs stalls so that a word is never lost while the
    // programmer is busy; a full buffer holds back character intake.
    rtpp_buf2 #(.W(BW)) u_buf (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (st_r.push),
        .in_ready  (buf_in_ready),
        .in_data   (st_r.push_word),
        .out_valid (buf_out_valid),
        .out_ready (take_out),
        .out_data  (buf_out_data)
    );

    assign word_valid = st_r.ovalid;
    assign word_addr  = st_r.oword[BW-1:DATA_W];
    assign word_data  = st_r.oword[DATA_W-1:0];
    assign rec_error  = st_r.err;
    assign done       = st_r.done;

endmodule

/* verification/rtpp_reader.sv */
// Behavioural tape reader model that paces characters into the parser.
module rtpp_reader (
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  rstn,
    // Character output
    output logic       char_tgl,
    output logic [7:0] char_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    int         ph;
    task automatic load(input logic [7:0] c);
        q.push_back(c);
    endtask
    // The code leads its toggle by a cycle and holds until the next one.
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            char_tgl <= 1'b0;
            char_code <= 8'h00;
            ph <= 0;
        end else if (ph == 9) begin
            char_tgl <= ~char_tgl;
            ph <= 8;
        end else if (ph > 0) begin
            ph <= ph - 1;
        end else if (q.size() > 0) begin
            char_code <= q.pop_front();
            ph <= 9;
        end
    end
endmodule

/* verification/rtpp_parser_asserts.sv */
// Port checker for the tape record parser.
module rtpp_parser_chk #(
    parameter int WORDS  = 256,
    parameter int DATA_W = 8,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rstn,
    // Watched ports
    input wire logic              char_tgl,
    input wire logic [7:0]        char_code,
    input wire logic              word_valid,
    input wire logic              word_ready,
    input wire logic [ADDR_W-1:0] word_addr,
    input wire logic [DATA_W-1:0] word_data,
    input wire logic              rec_error,
    input wire logic              done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    int acc_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) acc_r <= 0;
        else if (word_valid && word_ready) acc_r <= acc_r + 1;
    end
    a_valid_holds: assert property (
        word_valid && !word_ready |=> word_valid && $stable(word_addr) && $stable(word_data))
        else $error("word changed while stalled");
    a_err_sticky: assert property (rec_error |=> rec_error)
        else $error("error flag dropped");
    a_done_sticky: assert property (done |=> done)
        else $error("done dropped");
    a_addr_order: assert property (
        word_valid |-> word_addr == acc_r[ADDR_W-1:0]) else $error("address out of order");
    a_no_extra: assert property (acc_r >= WORDS |-> !word_valid)
        else $error("word beyond count");
    a_done_count: assert property (acc_r >= WORDS |-> done)
        else $error("done missing");
    a_drop_ready: assert property ($fell(word_valid) |-> $past(word_ready))
        else $error("word withdrawn");
    a_reset_clear: assert property (disable iff (1'b0)
        !rstn |-> !word_valid && !done && !rec_error) else $error("outputs set in reset");
endmodule
bind rtpp_parser rtpp_parser_chk #(.WORDS(WORDS), .DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk_i (
    .core_clk(core_clk), .rstn(rstn), .char_tgl(char_tgl), .char_code(char_code),
    .word_valid(word_valid), .word_ready(word_ready), .word_addr(word_addr),
    .word_data(word_data), .rec_error(rec_error), .done(done));

/* verification/tb_rtpp_parser.sv */
// Self-checking testbench for the tape record parser.
module tb_rom_tape_record_parser;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0;
    logic       rstn = 1'b1;
    logic       word_ready = 1'b0;
    logic       stall = 1'b1;
    logic       char_tgl;
    logic       word_valid;
    logic       rec_error;
    logic       done;
    logic [7:0] char_code;
    logic [1:0] word_addr;
    logic [7:0] word_data;
    logic [7:0] dat[4];
    logic [7:0] ga[$];
    logic [7:0] gd[$];
    logic [31:0] rnd;
    int         seed = 32'hd719;
    int         fails = 0;
    int         num_checks = 0;
    always #20 core_clk = ~core_clk;
    rtpp_reader rtpp_reader_i (.core_clk(core_clk), .rstn(rstn), .char_tgl(char_tgl),
        .char_code(char_code));
    rtpp_parser #(.WORDS(4)) rtpp_parser_i (.core_clk(core_clk), .rstn(rstn),
        .char_tgl(char_tgl), .char_code(char_code), .word_valid(word_valid),
        .word_ready(word_ready), .word_addr(word_addr), .word_data(word_data),
        .rec_error(rec_error), .done(done));
    always @(posedge core_clk) begin
        rnd = $random(seed);
        word_ready <= stall ? 1'b0 : rnd[0];
        if (rstn && word_valid && word_ready) begin
            ga.push_back({6'h00, word_addr});
            gd.push_back(word_data);
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    function automatic logic [7:0] pn(input logic b);
        return b ? rtpp_pkg::CH_HIGH : rtpp_pkg::CH_LOW;
    endfunction
    task automatic rec(input logic [7:0] d, input int n);
        rtpp_reader_i.load(rtpp_pkg::CH_START);
        for (int i = 0; i < n; i++) rtpp_reader_i.load(pn(d[(7 - i) & 7]));
        rtpp_reader_i.load(rtpp_pkg::CH_END);
    endtask
    task automatic settle();
        int k;
        for (k = 0; k < 3000 && rtpp_reader_i.q.size() > 0; k++) @(posedge core_clk);
        if (k == 3000) begin
            fails++;
            final_report();
        end
        repeat (40) @(posedge core_clk);
    endtask
    task automatic reset_dut();
        rstn <= 1'b0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        ga.delete();
        gd.delete();
    endtask
    initial begin
        reset_dut();
        dat[0] = 8'h80;
        dat[1] = 8'h01;
        dat[2] = 8'($random(seed));
        dat[3] = 8'($random(seed));
        for (int i = 0; i < 6; i++) rtpp_reader_i.load(i[0] ? 8'hff : 8'h00);
        rec(dat[0], 8);
        rec(dat[1], 8);
        settle();
        stall <= 1'b0;
        rec(dat[2], 8);
        rec(dat[3], 8);
        rtpp_reader_i.load(8'h0d);
        rtpp_reader_i.load(8'h0a);
        rec(8'h55, 8);
        rtpp_reader_i.load(8'h00);
        settle();
        for (int i = 0; i < 4; i++) begin
            chk("addr", ga[i], 8'(i));
            chk("data", gd[i], dat[i]);
        end
        chk("count", 8'(ga.size()), 8'h04);
        chk("done", {7'h00, done}, 8'h01);
        chk("clean error", {7'h00, rec_error}, 8'h00);
        $display("clean stream test finished");
        reset_dut();
        rtpp_reader_i.load(rtpp_pkg::CH_END);
        rec(8'h5a, 7);
        rec(8'h5a, 9);
        rtpp_reader_i.load(rtpp_pkg::CH_START);
        rtpp_reader_i.load(8'h58);
        rec(8'hc3, 8);
        settle();
        chk("bad error", {7'h00, rec_error}, 8'h01);
        chk("bad count", 8'(ga.size()), 8'h01);
        chk("bad addr", ga[0], 8'h00);
        chk("bad data", gd[0], 8'hc3);
        $display("faulty record test finished");
        final_report();
    end
endmodule
